// ### pkg/smcs_pkg.sv
// Shared constants and types of the serial peripheral master
package smcs_pkg;
   localparam logic [7:0] DIV_OFF        = 8'hD2;
   localparam logic [7:0] STAT_OFF       = 8'hD3;
   localparam logic [7:0] TXH_OFF        = 8'hD4;
   localparam logic [7:0] RXH_OFF        = 8'hD5;
   localparam logic [7:0] CTL_OFF        = 8'hD6;
   localparam logic [7:0] IEN_OFF        = 8'hD7;

   localparam logic [7:0] DIV_RESET      = 8'h04;
   localparam logic [7:0] STAT_RESET     = 8'h02;
   localparam logic [7:0] CTL_RESET      = 8'h00;
   localparam logic [7:0] IEN_RESET      = 8'h00;
   localparam logic [7:0] CTL_MASK       = 8'h7E;
   localparam logic [7:0] IEN_MASK       = 8'h0F;
   localparam logic [7:0] DIV_MASK       = 8'hFC;

   localparam int         TX_ON_BIT      = 6;
   localparam int         RX_ON_BIT      = 5;
   localparam int         IFACE_ON_BIT   = 4;
   localparam int         AUTO_SEL_BIT   = 3;
   localparam int         LSB_FIRST_BIT  = 2;
   localparam int         POLARITY_BIT   = 1;

   localparam int         BUSY_BIT       = 4;
   localparam int         XFER_END_BIT   = 3;
   localparam int         OVERRUN_BIT    = 2;
   localparam int         TX_EMPTY_BIT   = 1;
   localparam int         RX_FULL_BIT    = 0;

   localparam int         DATA_WIDTH     = 8;
   localparam int         FIFO_DEPTH     = 16;
   localparam int         FIFO_CNT_W     = 5;
   localparam logic [3:0] LAST_HALF_TICK = 4'hF;
   localparam logic [6:0] MIN_HALF       = 7'h02;

   typedef enum logic [1:0] {ST_IDLE, ST_SELECT, ST_SHIFT, ST_GAP} smcs_state_t;
endpackage : smcs_pkg

// ### pkg/smcs_stream_if.sv
// Valid/ready byte stream between the register side and the transmit queue
`timescale 1ns/100ps
interface smcs_stream_if #(parameter int WIDTH = 8) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : smcs_stream_if

// ### rtl/smcs_half_period.sv
// Half-period tick generator for the serial clock
`timescale 1ns/100ps
module smcs_half_period (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [6:0] half,
   output logic            tick
);
   logic [6:0] cnt_reg;

   assign tick = run && (cnt_reg == half - 7'h01);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_reg <= 7'h00;
      end else if (!run || tick) begin
         cnt_reg <= 7'h00;
      end else begin
         cnt_reg <= cnt_reg + 7'h01;
      end
   end
endmodule : smcs_half_period

// ### rtl/smcs_fifo.sv
// Transmit queue with a registered read stage
`timescale 1ns/100ps
module smcs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                      clock,
   input  wire logic                      rst,
   smcs_stream_if.snk                     push_side,
   smcs_stream_if.src                     pop_side,
   output logic [$clog2(DEPTH):0]         count
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      used_reg;
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             push;
   logic             refill;

   assign push_side.ready = (used_reg != (AW+1)'(DEPTH));
   assign push            = push_side.valid && push_side.ready;
   assign refill          = (used_reg != '0) && (!out_valid_reg || pop_side.ready);
   assign pop_side.valid  = out_valid_reg;
   assign pop_side.data   = out_data_reg;
   assign count           = used_reg + {{AW{1'b0}}, out_valid_reg};

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= push_side.data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         used_reg   <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (refill) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         used_reg <= used_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, refill};
      end
   end

   // Read data always leave through this register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end else if (refill) begin
         out_valid_reg <= 1'b1;
         out_data_reg  <= mem[rd_ptr_reg];
      end else if (pop_side.ready) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule : smcs_fifo

// ### rtl/smcs_spi_master.sv
// Serial peripheral master: registers, shift engine and pin drivers
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Transmitter off: no transfers, serial clock held at the polarity level.
// - Transmit only with tx_on set; receive only when rx_on also set.
// - Auto select drives select low before each byte, high after bit eight.
// - Auto select clear: select stays high, after any running byte finishes.
// - One interrupt output when any enabled status flag is set.
// - Reading status clears the transfer-end and overrun flags.
// - Receive-full sets on a new received byte, clears on holding read.
// - Busy bit reads one while a byte is being shifted.
// - Interface-enable bit clear disables the whole serial interface.
// - Bit-order control selects MSB first or LSB first both directions.
// - Polarity selects clock idle level and sampling edge.
// - Divider select bits 7..2 weigh 128 down to 4; reset value 04h.
// - Overrun flag sets when a receive overrun occurs.
// - Transfer-end flag sets when a transmission ends.
// - Status reads 02h after reset: only transmit-empty set.
// - Divisor is the sum of selected weights, 4 to 252.
// - Transmit and receive paths buffered for back-to-back transfers.
// - Eight bits full duplex; master drives data on each period's first edge.
module smcs_spi_master (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            irq,
   output logic            tx_space,
   output logic            serial_clock_out,
   output logic            serial_out,
   input  wire logic       serial_in,
   output logic            slave_select_out
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
      reg_hit = (addr == off);
   endfunction : reg_hit

   function automatic logic [7:0] reverse8(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         reverse8[i] = b[7-i];
      end
   endfunction : reverse8

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]            ctl_reg;
   logic [7:0]            ien_reg;
   logic [7:0]            div_reg;
   logic [7:0]            rx_holding_reg;
   logic [7:0]            shift_tx_reg;
   logic [7:0]            shift_rx_reg;
   logic [3:0]            tick_cnt_reg;
   logic                  sel_mode_reg;
   logic                  xfer_end_flag_reg;
   logic                  overrun_flag_reg;
   logic                  tx_empty_flag_reg;
   logic                  rx_full_flag_reg;
   logic [7:0]            sfr_rdata_reg;
   logic                  irq_reg;
   logic                  tx_space_reg;
   logic                  serial_clock_out_reg;
   logic                  serial_out_reg;
   logic                  slave_select_out_reg;
   smcs_pkg::smcs_state_t state_reg;

   logic                  tx_on, rx_on, interface_on, auto_sel, lsb_first, polarity;
   logic                  run_ok, tick, byte_done, load_now, store_rx, busy;
   logic                  wr_tx, rd_stat, rd_rx;
   logic [7:0]            rx_byte;
   logic [7:0]            status_value;
   logic [7:0]            read_value;
   logic [6:0]            half;
   logic [smcs_pkg::FIFO_CNT_W-1:0] fifo_count;

   smcs_stream_if #(.WIDTH(smcs_pkg::DATA_WIDTH)) push_if ();
   smcs_stream_if #(.WIDTH(smcs_pkg::DATA_WIDTH)) pop_if ();

   assign sfr_rdata        = sfr_rdata_reg;
   assign irq              = irq_reg;
   assign tx_space         = tx_space_reg;
   assign serial_clock_out = serial_clock_out_reg;
   assign serial_out       = serial_out_reg;
   assign slave_select_out = slave_select_out_reg;

   assign tx_on        = ctl_reg[smcs_pkg::TX_ON_BIT];
   assign rx_on        = ctl_reg[smcs_pkg::RX_ON_BIT];
   assign interface_on = ctl_reg[smcs_pkg::IFACE_ON_BIT];
   assign auto_sel     = ctl_reg[smcs_pkg::AUTO_SEL_BIT];
   assign lsb_first    = ctl_reg[smcs_pkg::LSB_FIRST_BIT];
   assign polarity     = ctl_reg[smcs_pkg::POLARITY_BIT];

   assign wr_tx   = sfr_wr && reg_hit(sfr_addr, smcs_pkg::TXH_OFF);
   assign rd_stat = sfr_rd && reg_hit(sfr_addr, smcs_pkg::STAT_OFF);
   assign rd_rx   = sfr_rd && reg_hit(sfr_addr, smcs_pkg::RXH_OFF);

   // Both enables must stand for the shifter to run
   assign run_ok    = tx_on && interface_on;
   assign busy      = (state_reg != smcs_pkg::ST_IDLE);
   assign byte_done = (state_reg == smcs_pkg::ST_SHIFT) && tick
                      && (tick_cnt_reg == smcs_pkg::LAST_HALF_TICK);
   assign load_now  = pop_if.valid && run_ok
                      && ((state_reg == smcs_pkg::ST_IDLE) || byte_done);
   assign store_rx  = byte_done && run_ok && rx_on;
   assign rx_byte   = {shift_rx_reg[6:0], serial_in};

   ////////////////////////////////////////////////////////////////////////////
   // Transmit queue; a write while it is full is dropped
   assign push_if.valid = wr_tx;
   assign push_if.data  = sfr_wdata;
   assign pop_if.ready  = load_now;

   smcs_fifo #(
      .WIDTH (smcs_pkg::DATA_WIDTH),
      .DEPTH (smcs_pkg::FIFO_DEPTH)
   ) u_tx_fifo (
      .clock     (clock),
      .rst       (rst),
      .push_side (push_if),
      .pop_side  (pop_if),
      .count     (fifo_count)
   );

   // Half period is half the summed divisor; an all-zero selection runs at the fastest rate
   assign half = (div_reg[7:2] == 6'h00) ? smcs_pkg::MIN_HALF : {div_reg[7:2], 1'b0};

   smcs_half_period u_half_period (
      .clock (clock),
      .rst   (rst),
      .run   (busy),
      .half  (half),
      .tick  (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctl_reg <= smcs_pkg::CTL_RESET;
         ien_reg <= smcs_pkg::IEN_RESET;
         div_reg <= smcs_pkg::DIV_RESET;
      end else if (sfr_wr) begin
         if (reg_hit(sfr_addr, smcs_pkg::CTL_OFF)) begin
            ctl_reg <= sfr_wdata & smcs_pkg::CTL_MASK;
         end
         if (reg_hit(sfr_addr, smcs_pkg::IEN_OFF)) begin
            ien_reg <= sfr_wdata & smcs_pkg::IEN_MASK;
         end
         if (reg_hit(sfr_addr, smcs_pkg::DIV_OFF)) begin
            div_reg <= sfr_wdata & smcs_pkg::DIV_MASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads; data appear one edge after the strobe
   always_comb begin
      status_value = 8'h00;
      status_value[smcs_pkg::BUSY_BIT]     = busy;
      status_value[smcs_pkg::XFER_END_BIT] = xfer_end_flag_reg;
      status_value[smcs_pkg::OVERRUN_BIT]  = overrun_flag_reg;
      status_value[smcs_pkg::TX_EMPTY_BIT] = tx_empty_flag_reg;
      status_value[smcs_pkg::RX_FULL_BIT]  = rx_full_flag_reg;
      case (sfr_addr)
         smcs_pkg::DIV_OFF:  read_value = div_reg;
         smcs_pkg::STAT_OFF: read_value = status_value;
         smcs_pkg::RXH_OFF:  read_value = rx_holding_reg;
         smcs_pkg::CTL_OFF:  read_value = ctl_reg;
         smcs_pkg::IEN_OFF:  read_value = ien_reg;
         default:            read_value = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_rdata_reg <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata_reg <= read_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags; a set in the same cycle as a clear always wins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         xfer_end_flag_reg <= smcs_pkg::STAT_RESET[smcs_pkg::XFER_END_BIT];
         overrun_flag_reg  <= smcs_pkg::STAT_RESET[smcs_pkg::OVERRUN_BIT];
         tx_empty_flag_reg <= smcs_pkg::STAT_RESET[smcs_pkg::TX_EMPTY_BIT];
         rx_full_flag_reg  <= smcs_pkg::STAT_RESET[smcs_pkg::RX_FULL_BIT];
      end else begin
         if (byte_done && !load_now) begin
            xfer_end_flag_reg <= 1'b1;
         end else if (rd_stat) begin
            xfer_end_flag_reg <= 1'b0;
         end
         if (store_rx && rx_full_flag_reg && !rd_rx) begin
            overrun_flag_reg <= 1'b1;
         end else if (rd_stat) begin
            overrun_flag_reg <= 1'b0;
         end
         if (load_now && (fifo_count == smcs_pkg::FIFO_CNT_W'(1))) begin
            tx_empty_flag_reg <= 1'b1;
         end else if (wr_tx) begin
            tx_empty_flag_reg <= 1'b0;
         end
         if (store_rx) begin
            rx_full_flag_reg <= 1'b1;
         end else if (rd_rx) begin
            rx_full_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_reg      <= 1'b0;
         tx_space_reg <= 1'b0;
      end else begin
         irq_reg      <= |(ien_reg[3:0] & {xfer_end_flag_reg, overrun_flag_reg,
                                           tx_empty_flag_reg, rx_full_flag_reg});
         tx_space_reg <= push_if.ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive holding register: old byte is overwritten on overrun
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_holding_reg <= 8'h00;
      end else if (store_rx) begin
         rx_holding_reg <= lsb_first ? reverse8(rx_byte) : rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift engine state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg    <= smcs_pkg::ST_IDLE;
         tick_cnt_reg <= 4'h0;
         sel_mode_reg <= 1'b0;
      end else if (!run_ok) begin
         state_reg    <= smcs_pkg::ST_IDLE;
         tick_cnt_reg <= 4'h0;
      end else begin
         if (load_now) begin
            sel_mode_reg <= auto_sel;
         end
         case (state_reg)
            smcs_pkg::ST_IDLE: begin
               if (load_now) begin
                  state_reg <= smcs_pkg::ST_SELECT;
               end
            end
            smcs_pkg::ST_SELECT: begin
               if (tick) begin
                  state_reg    <= smcs_pkg::ST_SHIFT;
                  tick_cnt_reg <= 4'h0;
               end
            end
            smcs_pkg::ST_SHIFT: begin
               if (tick) begin
                  tick_cnt_reg <= tick_cnt_reg + 4'h1;
               end
               if (byte_done) begin
                  if (!load_now) begin
                     state_reg <= smcs_pkg::ST_IDLE;
                  end else if (auto_sel) begin
                     state_reg <= smcs_pkg::ST_GAP;
                  end else begin
                     state_reg <= smcs_pkg::ST_SHIFT;
                  end
               end
            end
            smcs_pkg::ST_GAP: begin
               if (tick) begin
                  state_reg <= smcs_pkg::ST_SELECT;
               end
            end
            default: begin
               state_reg <= smcs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift registers and serial clock; data change on each period's first edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shift_tx_reg         <= 8'h00;
         shift_rx_reg         <= 8'h00;
         serial_out_reg       <= 1'b0;
         serial_clock_out_reg <= 1'b0;
      end else begin
         if (load_now) begin
            shift_tx_reg <= lsb_first ? reverse8(pop_if.data) : pop_if.data;
         end
         if (run_ok && (state_reg == smcs_pkg::ST_SHIFT) && tick && !tick_cnt_reg[0]) begin
            serial_clock_out_reg <= ~polarity;
            serial_out_reg       <= shift_tx_reg[7];
            shift_tx_reg         <= {shift_tx_reg[6:0], 1'b0};
         end else if (run_ok && (state_reg == smcs_pkg::ST_SHIFT) && tick) begin
            // Sampled on the trailing edge, half a period after the slave drove it
            serial_clock_out_reg <= polarity;
            shift_rx_reg         <= rx_byte;
         end else if (!run_ok || (state_reg != smcs_pkg::ST_SHIFT)) begin
            serial_clock_out_reg <= polarity;
         end
      end
   end

   // Select follows the mode latched with the byte, so clearing it never cuts a byte short
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         slave_select_out_reg <= 1'b1;
      end else begin
         slave_select_out_reg <= !(run_ok && sel_mode_reg
                                   && ((state_reg == smcs_pkg::ST_SELECT)
                                       || (state_reg == smcs_pkg::ST_SHIFT)));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   a_idle_clock_level: assert property ((state_reg != smcs_pkg::ST_SHIFT)
      |=> (serial_clock_out == $past(polarity)))
      else $error("serial clock not at idle level outside shifting");
   a_off_stops_engine: assert property (!run_ok |=> (state_reg == smcs_pkg::ST_IDLE))
      else $error("engine running while disabled");
   a_rx_gated_off: assert property ((byte_done && !rx_on) |=> $stable(rx_holding_reg))
      else $error("receive holding changed with receiver off");
   a_select_during_byte: assert property (
      (sel_mode_reg && (state_reg == smcs_pkg::ST_SHIFT) && run_ok) |=> !slave_select_out)
      else $error("select high during auto-select byte");
   a_select_idle_high: assert property ((state_reg == smcs_pkg::ST_IDLE) |=> slave_select_out)
      else $error("select low while idle");
   a_irq_follows_flags: assert property (
      (ien_reg[smcs_pkg::RX_FULL_BIT] && rx_full_flag_reg) |=> irq)
      else $error("enabled flag did not raise interrupt");
   a_status_read_clears: assert property ((rd_stat && !byte_done) |=> !xfer_end_flag_reg)
      else $error("transfer-end flag survived status read");
   a_tx_empty_sets: assert property (
      (load_now && (fifo_count == smcs_pkg::FIFO_CNT_W'(1))) |=> tx_empty_flag_reg)
      else $error("transmit-empty not set after last byte loaded");
   a_rx_full_sets: assert property (store_rx |=> (rx_full_flag_reg && rx_holding_reg ==
      ($past(lsb_first) ? reverse8($past(rx_byte)) : $past(rx_byte))))
      else $error("received byte not stored");
   a_busy_reads_back: assert property (rd_stat |=> (sfr_rdata[smcs_pkg::BUSY_BIT] == $past(busy)))
      else $error("busy bit misreported");
   a_overrun_sets: assert property ((store_rx && rx_full_flag_reg && !rd_rx) |=> overrun_flag_reg)
      else $error("overrun not flagged");
   a_byte_ends_idle: assert property ((byte_done && !load_now) |=> (xfer_end_flag_reg
      && state_reg == smcs_pkg::ST_IDLE) [*1] ##1 (!busy || state_reg == smcs_pkg::ST_SELECT))
      else $error("transfer end not reached");

   c_back_to_back: cover property (byte_done && load_now);
   c_overrun: cover property (store_rx && rx_full_flag_reg);
   c_auto_select_gap: cover property (state_reg == smcs_pkg::ST_GAP);
   c_transfer_end: cover property (byte_done && !load_now);
endmodule : smcs_spi_master

// ### dv/smcs_slave_model.sv
// Serial slave model for clock polarity 0 with fixed reply byte
`timescale 1ns/100ps
module smcs_slave_model #(
   parameter logic [7:0] REPLY = 8'hC1
) (
   input  wire logic       sclk,
   input  wire logic       sel_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic      [7:0] got
);
   int n = 0;
   initial miso = 1'b0;
   // Deselected line toggles so a stale bit never reads as valid data
   always @(posedge sclk or posedge sel_n) begin
      if (sel_n) begin
         n = 0;
         miso = ~miso;
      end else if (n < 8) begin
         miso = REPLY[7-n];
         n = n + 1;
      end
   end
   always @(negedge sclk) if (!sel_n) got = {got[6:0], mosi};
endmodule : smcs_slave_model

// ### dv/spi_master_control_status_tb.sv
// Self-checking bench of the serial peripheral master
`timescale 1ns/100ps
module spi_master_control_status_tb;
   logic clock = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, irq, sclk, mosi, miso, sel_n, tx_space;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, got;
   int num_errors = 0, checked = 0;
   always #10 clock = ~clock;
   smcs_spi_master smcs_spi_master_i (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq(irq), .tx_space(tx_space),
      .serial_clock_out(sclk), .serial_out(mosi), .serial_in(miso), .slave_select_out(sel_n));
   smcs_slave_model smcs_slave_model_i (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso), .got(got));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clock);
      sfr_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clock);
      sfr_rd <= 1'b0;
      #1 chk("rdata", sfr_rdata & m, e);
   endtask : rd
   // Sends one byte and waits for select to drop and rise again
   task automatic send(input logic [7:0] d);
      int k;
      k = 0;
      wr(smcs_pkg::TXH_OFF, d);
      while (sel_n !== 1'b0 && k < 100) begin
         @(posedge clock);
         k++;
      end
      chk("select_low", {7'h00, sel_n}, 8'h00);
      rd(smcs_pkg::STAT_OFF, 8'h10, 8'h10);
      while (sel_n !== 1'b1 && k < 300) begin
         @(posedge clock);
         k++;
      end
      repeat (4) @(posedge clock);
   endtask : send
   task automatic t_reset;
      rd(smcs_pkg::DIV_OFF, 8'hFF, 8'h04);
      rd(smcs_pkg::STAT_OFF, 8'hFF, 8'h02);
      rd(smcs_pkg::CTL_OFF, 8'hFF, 8'h00);
      rd(8'hD0, 8'hFF, 8'h00);
      chk("sclk_idle", {7'h00, sclk}, 8'h00);
      chk("tx_space", {7'h00, tx_space}, 8'h01);
   endtask : t_reset
   task automatic t_irq;
      wr(smcs_pkg::IEN_OFF, 8'h02);
      repeat (2) @(posedge clock);
      chk("irq_on", {7'h00, irq}, 8'h01);
      wr(smcs_pkg::IEN_OFF, 8'h00);
      repeat (2) @(posedge clock);
      chk("irq_off", {7'h00, irq}, 8'h00);
   endtask : t_irq
   task automatic t_msb;
      wr(smcs_pkg::CTL_OFF, 8'h78);
      send(8'h3C);
      chk("slave_got", got, 8'h3C);
      rd(smcs_pkg::RXH_OFF, 8'hFF, 8'hC1);
      rd(smcs_pkg::STAT_OFF, 8'hFF, 8'h0A);
      rd(smcs_pkg::STAT_OFF, 8'hFF, 8'h02);
   endtask : t_msb
   task automatic t_lsb_overrun;
      wr(smcs_pkg::CTL_OFF, 8'h7C);
      send(8'h01);
      send(8'h01);
      chk("slave_got_lsb", got, 8'h80);
      rd(smcs_pkg::STAT_OFF, 8'h04, 8'h04);
      rd(smcs_pkg::RXH_OFF, 8'hFF, 8'h83);
   endtask : t_lsb_overrun
   // Receiver off, a slower divider, then the interface off with a byte left queued
   task automatic t_gated;
      int c;
      c = 0;
      wr(smcs_pkg::CTL_OFF, 8'h58);
      send(8'h5A);
      chk("slave_got_norx", got, 8'h5A);
      rd(smcs_pkg::STAT_OFF, 8'h0F, 8'h0A);
      rd(smcs_pkg::RXH_OFF, 8'hFF, 8'h83);
      wr(smcs_pkg::DIV_OFF, 8'h0C);
      wr(smcs_pkg::TXH_OFF, 8'h96);
      while (sclk !== 1'b1 && c < 200) begin
         @(posedge clock);
         c++;
      end
      c = 0;
      while (sclk !== 1'b0 && c < 200) begin
         @(posedge clock);
         c++;
      end
      chk("sclk_high_cycles", c[7:0], 8'h06);
      while (sel_n !== 1'b1 && c < 400) begin
         @(posedge clock);
         c++;
      end
      wr(smcs_pkg::CTL_OFF, 8'h68);
      wr(smcs_pkg::TXH_OFF, 8'hA5);
      repeat (40) @(posedge clock);
      chk("select_iface_off", {7'h00, sel_n}, 8'h01);
      rd(smcs_pkg::STAT_OFF, 8'h13, 8'h00);
   endtask : t_gated
   task automatic t_off_polarity;
      wr(smcs_pkg::CTL_OFF, 8'h12);
      repeat (4) @(posedge clock);
      chk("sclk_pol1", {7'h00, sclk}, 8'h01);
   endtask : t_off_polarity
   task automatic report_and_stop;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      #500000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_irq();
      t_msb();
      t_lsb_overrun();
      t_gated();
      t_off_polarity();
      report_and_stop();
   end
endmodule : spi_master_control_status_tb
